/* hdl/iep_arb_if.sv */
interface iep_arb_if;
  logic [iep_pkg::NSRC-1:0] req;
  logic [iep_pkg::NSRC-1:0] hi;
  logic [4:0]               vec;
  logic                     vec_hi;
  logic                     valid;
  modport ctrl (output req, output hi, input vec, input vec_hi, input valid);
  modport arb  (input req, input hi, output vec, output vec_hi, output valid);
endinterface : iep_arb_if

/* hdl/iep_arbiter.sv */
module iep_arbiter
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Request side
  iep_arb_if.arb    a
);
  logic [4:0] vec_d;
  logic       hi_d;
  logic       val_d;

  // High level first, then lowest vector
  always_comb
  begin
    vec_d = iep_pkg::NO_VECTOR;
    hi_d  = 1'b0;
    val_d = 1'b0;
    for (int i = iep_pkg::NSRC - 1; i >= 0; i--)
    begin
      if (a.req[i] && a.hi[i])
      begin
        vec_d = 5'(i);
        hi_d  = 1'b1;
        val_d = 1'b1;
      end
    end
    if (!val_d)
    begin
      for (int i = iep_pkg::NSRC - 1; i >= 0; i--)
      begin
        if (a.req[i])
        begin
          vec_d = 5'(i);
          val_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      a.vec    <= iep_pkg::NO_VECTOR;
      a.vec_hi <= 1'b0;
      a.valid  <= 1'b0;
    end
    else
    begin
      a.vec    <= vec_d;
      a.vec_hi <= hi_d;
      a.valid  <= val_d;
    end
  end
endmodule // iep_arbiter

/* hdl/iep_ctrl.sv */
// What this block does
// - Priority 1 bits 7 and 6 set timer 4 and timer 3 priority high.
// - Priority 1 bits 5 and 4 set comparator and touch priority high.
// - Priority 1 bits 3 and 2 set external 2 and base tick priority.
// - Priority 1 bits 1 and 0 set pulse width and serial 0; reset zero.
// - Enable 2 bits 4..0 enable serial units 5..1; reset zero.
// - Priority 2 bits 4..0 set serial 5..1 priority; reset zero.
// - External 1 event sets timer control bit 3; cleared on acceptance.
// - External 0 event sets timer control bit 1; cleared on acceptance.
// - Falling register bits 7..4 enable falling edges on external 0 inputs 7..4.
// - Global enable zero blocks all interrupts; one allows enabled ones.
// - High priority preempts low; equal priority serves lower vector first.
// - Rising register bits 7..4 enable rising edges on external 0 inputs 7..4.
//
// Chosen here: the Wishbone slave port.
module iep_ctrl
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Peripheral sources: group 1 bit order, serial 5..1
  input  wire logic [7:0]  group1_irq,
  input  wire logic [4:0]  serial_irq,
  input  wire logic [7:4]  external_irq_zero,
  input  wire logic        external_irq_one,
  // Core side
  output logic             irq_req,
  output logic [4:0]       irq_vector,
  output logic             irq_high,
  input  wire logic        irq_accept,
  input  wire logic        irq_return
);
  iep_arb_if arb_if ();

  logic [7:0] irq_prio_1_q;
  logic [7:0] irq_enable_1_q;
  logic [4:0] serial_irq_enable_2_q;
  logic [4:0] serial_irq_priority_2_q;
  logic [7:4] ext0_fall_en_n_q;
  logic [7:4] ext0_rise_en_n_q;
  logic       global_irq_enable_q;
  logic       ext0_en_q;
  logic       ext1_en_q;
  logic       ext0_request_flag_q;
  logic       ext1_request_flag_q;
  logic [7:4] ext0_s1_q;
  logic [7:4] ext0_s2_q;
  logic [7:4] ext0_s3_q;
  logic       ext1_s1_q;
  logic       ext1_s2_q;
  logic       ext1_s3_q;
  logic [1:0] active_q;
  logic [4:0] serving_q;
  logic       ack_q;
  logic       acc_ok;
  logic       wr;
  logic       ext0_event;
  logic       ext1_event;
  logic [7:0] rdata;
  logic       hit;
  logic       take;
  // Per-register write strobes and edge hits
  logic [7:4] ext0_fall_hit;
  logic [7:4] ext0_rise_hit;
  logic       wr_timer_control;
  logic       wr_prio1;
  logic       wr_en1;
  logic       wr_en2;
  logic       wr_prio2;
  logic       wr_fall;
  logic       wr_rise;
  logic       wr_glob;

  assign acc_ok = wb_cyc_i && wb_stb_i && !ack_q && !wb_err_o;
  assign wr     = acc_ok && wb_we_i && wb_sel_i[0] && hit;
  assign take   = irq_accept && irq_req;

  // Write strobes, one per register
  assign wr_timer_control  = wr && wb_adr_i[11:2] == iep_pkg::TIMER_CONTROL_IDX;
  assign wr_prio1 = wr && wb_adr_i[11:2] == iep_pkg::IRQ_PRIO1_IDX;
  assign wr_en1   = wr && wb_adr_i[11:2] == iep_pkg::IRQ_ENABLE1_IDX;
  assign wr_en2   = wr && wb_adr_i[11:2] == iep_pkg::SERIAL_EN2_IDX;
  assign wr_prio2 = wr && wb_adr_i[11:2] == iep_pkg::SERIAL_PRIO2_IDX;
  assign wr_fall  = wr && wb_adr_i[11:2] == iep_pkg::EXT0_FALL_IDX;
  assign wr_rise  = wr && wb_adr_i[11:2] == iep_pkg::EXT0_RISE_IDX;
  assign wr_glob  = wr && wb_adr_i[11:2] == iep_pkg::GLOBAL_CTRL_IDX;

  // Pin synchronisers, external 0
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ext0_s1_q <= 4'h0;
      ext0_s2_q <= 4'h0;
      ext0_s3_q <= 4'h0;
    end
    else
    begin
      ext0_s1_q <= external_irq_zero;
      ext0_s2_q <= ext0_s1_q;
      ext0_s3_q <= ext0_s2_q;
    end
  end

  // Pin synchronisers, external 1
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ext1_s1_q <= 1'b0;
      ext1_s2_q <= 1'b0;
      ext1_s3_q <= 1'b0;
    end
    else
    begin
      ext1_s1_q <= external_irq_one;
      ext1_s2_q <= ext1_s1_q;
      ext1_s3_q <= ext1_s2_q;
    end
  end

  // Edge detection, one slice per external 0 input
  for (genvar n = 4; n < 8; n++)
  begin : g_edge
    assign ext0_fall_hit[n] = ext0_fall_en_n_q[n] && ext0_s3_q[n] && !ext0_s2_q[n];
    assign ext0_rise_hit[n] = ext0_rise_en_n_q[n] && !ext0_s3_q[n] && ext0_s2_q[n];
  end
  assign ext0_event = (|ext0_fall_hit) || (|ext0_rise_hit);

  // External 1 events are falling edges only
  assign ext1_event = ext1_s3_q && !ext1_s2_q;

  // Request flags: set wins over accept clear and software write
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ext1_request_flag_q <= 1'b0;
    else if (ext1_event)
      ext1_request_flag_q <= 1'b1;
    else if (take && arb_if.vec == 5'h0e)
      ext1_request_flag_q <= 1'b0;
    else if (wr_timer_control)
      ext1_request_flag_q <= wb_dat_i[iep_pkg::EXT1_FLAG_POS];
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ext0_request_flag_q <= 1'b0;
    else if (ext0_event)
      ext0_request_flag_q <= 1'b1;
    else if (take && arb_if.vec == 5'h0d)
      ext0_request_flag_q <= 1'b0;
    else if (wr_timer_control)
      ext0_request_flag_q <= wb_dat_i[iep_pkg::EXT0_FLAG_POS];
  end

  // Priority 1: one level bit per group 1 source
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      irq_prio_1_q <= iep_pkg::REG_RESET;
    else if (wr_prio1)
      irq_prio_1_q <= wb_dat_i[7:0];
  end

  // Enable 1: one enable bit per group 1 source
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      irq_enable_1_q <= iep_pkg::REG_RESET;
    else if (wr_en1)
      irq_enable_1_q <= wb_dat_i[7:0];
  end

  // Enable 2: serial units 5..1, upper bits dropped
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      serial_irq_enable_2_q <= iep_pkg::REG_RESET[4:0];
    else if (wr_en2)
      serial_irq_enable_2_q <= wb_dat_i[4:0];
  end

  // Priority 2: serial units 5..1, upper bits dropped
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      serial_irq_priority_2_q <= iep_pkg::REG_RESET[4:0];
    else if (wr_prio2)
      serial_irq_priority_2_q <= wb_dat_i[4:0];
  end

  // Falling edge enables, low nibble dropped
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ext0_fall_en_n_q <= iep_pkg::REG_RESET[7:4];
    else if (wr_fall)
      ext0_fall_en_n_q <= wb_dat_i[7:4];
  end

  // Rising edge enables, low nibble dropped
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ext0_rise_en_n_q <= iep_pkg::REG_RESET[7:4];
    else if (wr_rise)
      ext0_rise_en_n_q <= wb_dat_i[7:4];
  end

  // Global and external enables
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      global_irq_enable_q <= 1'b0;
      ext1_en_q           <= 1'b0;
      ext0_en_q           <= 1'b0;
    end
    else if (wr_glob)
    begin
      global_irq_enable_q <= wb_dat_i[iep_pkg::GLOBAL_EN_POS];
      ext1_en_q           <= wb_dat_i[2];
      ext0_en_q           <= wb_dat_i[0];
    end
  end

  // Gated requests: group 1 at 0..7, serial 1..5 at 8..12, ext0 13, ext1 14
  always_comb
  begin
    arb_if.req = '0;
    arb_if.hi  = '0;
    if (global_irq_enable_q)
    begin
      arb_if.req[7:0]   = group1_irq & irq_enable_1_q;
      arb_if.req[12:8]  = serial_irq & serial_irq_enable_2_q;
      arb_if.req[13]    = ext0_request_flag_q && ext0_en_q;
      arb_if.req[14]    = ext1_request_flag_q && ext1_en_q;
    end
    arb_if.hi[7:0]  = irq_prio_1_q;
    arb_if.hi[12:8] = serial_irq_priority_2_q;
    arb_if.hi[13]   = 1'b0;
    arb_if.hi[14]   = 1'b0;
  end

  iep_arbiter u_arb
  (
    .ref_clk (ref_clk),
    .reset   (reset),
    .a       (arb_if.arb)
  );

  // Service level tracking: bit 1 high active, bit 0 low active
  // A return closes the innermost routine before a new one opens
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      active_q  <= 2'b00;
      serving_q <= iep_pkg::NO_VECTOR;
    end
    else
    begin
      if (irq_return)
      begin
        if (active_q[1])
          active_q[1] <= 1'b0;
        else
          active_q[0] <= 1'b0;
      end
      if (take)
      begin
        active_q[arb_if.vec_hi] <= 1'b1;
        serving_q               <= arb_if.vec;
      end
    end
  end

  // Only a high request preempts a low routine
  always_comb
  begin
    irq_req = arb_if.valid && !active_q[1] && (!active_q[0] || arb_if.vec_hi);
  end
  assign irq_vector = arb_if.vec;
  assign irq_high   = arb_if.vec_hi;

  // Read mux
  always_comb
  begin
    rdata = 8'h00;
    hit   = 1'b1;
    case (wb_adr_i[11:2])
      iep_pkg::TIMER_CONTROL_IDX:
        rdata = {4'h0, ext1_request_flag_q, 1'b0, ext0_request_flag_q, 1'b0};
      iep_pkg::IRQ_PRIO1_IDX:    rdata = irq_prio_1_q;
      iep_pkg::IRQ_ENABLE1_IDX:  rdata = irq_enable_1_q;
      iep_pkg::SERIAL_EN2_IDX:   rdata = {3'h0, serial_irq_enable_2_q};
      iep_pkg::SERIAL_PRIO2_IDX: rdata = {3'h0, serial_irq_priority_2_q};
      iep_pkg::EXT0_FALL_IDX:    rdata = {ext0_fall_en_n_q, 4'h0};
      iep_pkg::EXT0_RISE_IDX:    rdata = {ext0_rise_en_n_q, 4'h0};
      iep_pkg::GLOBAL_CTRL_IDX:
        rdata = {global_irq_enable_q, 4'h0, ext1_en_q, 1'b0, ext0_en_q};
      iep_pkg::PENDING_IDX:      rdata = {arb_if.valid, arb_if.vec_hi, 1'b0, arb_if.vec};
      iep_pkg::SERVICE_IDX:      rdata = {active_q, 1'b0, serving_q};
      default:                   hit = 1'b0;
    endcase
  end

  // Bus answer, one cycle after the request
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ack_q    <= 1'b0;
      wb_err_o <= 1'b0;
    end
    else
    begin
      ack_q    <= acc_ok && hit;
      wb_err_o <= acc_ok && !hit;
    end
  end

  // Read data, registered with the answer
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      wb_dat_o <= 32'h0000_0000;
    else
      wb_dat_o <= {24'h00_0000, rdata};
  end
  assign wb_ack_o = ack_q;
endmodule // iep_ctrl

/* hdl/iep_pkg.sv */
package iep_pkg;
  // Register word indices on the bus (byte address is four times the index)
  localparam logic [9:0] TIMER_CONTROL_IDX = 10'h088;
  localparam logic [9:0] SERIAL_EN2_IDX    = 10'h0aa;
  localparam logic [9:0] EXT0_FALL_IDX     = 10'h0b4;
  localparam logic [9:0] SERIAL_PRIO2_IDX  = 10'h0ba;
  localparam logic [9:0] EXT0_RISE_IDX     = 10'h0bb;
  localparam logic [9:0] IRQ_PRIO1_IDX     = 10'h0b9;
  localparam logic [9:0] IRQ_ENABLE1_IDX   = 10'h0a9;
  localparam logic [9:0] GLOBAL_CTRL_IDX   = 10'h0a8;
  localparam logic [9:0] PENDING_IDX       = 10'h0c0;
  localparam logic [9:0] SERVICE_IDX       = 10'h0c1;
  // Field positions
  localparam int EXT1_FLAG_POS  = 3;
  localparam int EXT0_FLAG_POS  = 1;
  localparam int GLOBAL_EN_POS  = 7;
  localparam int SERIAL_HI_POS  = 4;
  localparam int EDGE_LO_POS    = 4;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  // Source count: 8 of group 1, 5 serial, ext0, ext1
  localparam int NSRC = 15;
  localparam logic [4:0] NO_VECTOR = 5'h1f;
endpackage : iep_pkg

/* testbench/iep_core_model.sv */
module iep_core_model
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Bench control
  input wire logic run,
  input wire logic slow,
  // Core side
  input wire logic irq_req,
  output logic     irq_accept,
  output logic     irq_return
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_q;
  // Takes a request promptly or late, ends the routine a cycle later
  always_ff @(posedge ref_clk)
  begin
    irq_accept <= !reset && run && cnt_q == 4'h2;
    irq_return <= !reset && run && cnt_q == 4'h1;
    if (reset || !run)
      cnt_q <= 4'h0;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    else if (irq_req)
      cnt_q <= slow ? 4'h8 : 4'h2;
  end
endmodule // iep_core_model

/* testbench/iep_ctrl_monitor.sv */
module iep_ctrl_monitor
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  logic       rd;
  logic [9:0] wa;
  assign rd = wb_ack_o && !wb_we_i;
  assign wa = wb_adr_i[11:2];
  property p_ans;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o;
  endproperty
  a_ans: assert property (p_ans) else $error("no single answer");
  property p_one;
    wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o;
  endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_top;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000;
  endproperty
  a_top: assert property (p_top) else $error("upper data set");
  property p_timer_control;
    rd && wa == iep_pkg::TIMER_CONTROL_IDX |-> wb_dat_o[2] == 1'b0 && wb_dat_o[0] == 1'b0;
  endproperty
  a_timer_control: assert property (p_timer_control) else $error("timer ctrl spare");
  property p_en2;
    rd && wa == iep_pkg::SERIAL_EN2_IDX |-> wb_dat_o[7:5] == 3'h0;
  endproperty
  a_en2: assert property (p_en2) else $error("enable 2 spare");
  property p_pr2;
    rd && wa == iep_pkg::SERIAL_PRIO2_IDX |-> wb_dat_o[7:5] == 3'h0;
  endproperty
  a_pr2: assert property (p_pr2) else $error("priority 2 spare");
  property p_fall;
    rd && wa == iep_pkg::EXT0_FALL_IDX |-> wb_dat_o[3:0] == 4'h0;
  endproperty
  a_fall: assert property (p_fall) else $error("falling spare");
  property p_rise;
    rd && wa == iep_pkg::EXT0_RISE_IDX |-> wb_dat_o[3:0] == 4'h0;
  endproperty
  a_rise: assert property (p_rise) else $error("rising spare");
endmodule // iep_ctrl_monitor

/* testbench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [7:0]  group1_irq = 8'h00;
  logic [4:0]  serial_irq = 5'h00;
  logic [7:4]  external_irq_zero = 4'hf;
  logic        external_irq_one = 1'b1;
  logic        run = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] wb_dat_o, q;
  logic        wb_ack_o, wb_err_o, irq_req, irq_high, irq_accept, irq_return, e;
  logic [4:0]  irq_vector;
  logic [31:0] rnd = 32'h5ae7_32ba;
  logic [7:0]  p1;
  logic [5:0]  exp_v;
  int          n_errors = 0;
  int          total_checks = 0;
  int          i, k;
  logic [9:0]  ra [6] = '{iep_pkg::IRQ_PRIO1_IDX, iep_pkg::SERIAL_EN2_IDX,
    iep_pkg::SERIAL_PRIO2_IDX, iep_pkg::EXT0_FALL_IDX, iep_pkg::EXT0_RISE_IDX,
    iep_pkg::TIMER_CONTROL_IDX};
  logic [7:0]  rm [6] = '{8'hff, 8'h1f, 8'h1f, 8'hf0, 8'hf0, 8'h0a};
  iep_ctrl DUT
  (
    .ref_clk           (ref_clk),
    .reset             (reset),
    .wb_cyc_i          (wb_cyc_i),
    .wb_stb_i          (wb_stb_i),
    .wb_we_i           (wb_we_i),
    .wb_adr_i          (wb_adr_i),
    .wb_sel_i          (wb_sel_i),
    .wb_dat_i          (wb_dat_i),
    .wb_dat_o          (wb_dat_o),
    .wb_ack_o          (wb_ack_o),
    .wb_err_o          (wb_err_o),
    .group1_irq        (group1_irq),
    .serial_irq        (serial_irq),
    .external_irq_zero (external_irq_zero),
    .external_irq_one  (external_irq_one),
    .irq_req           (irq_req),
    .irq_vector        (irq_vector),
    .irq_high          (irq_high),
    .irq_accept        (irq_accept),
    .irq_return        (irq_return)
  );
  iep_core_model core
  (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .run        (run),
    .slow       (slow),
    .irq_req    (irq_req),
    .irq_accept (irq_accept),
    .irq_return (irq_return)
  );
  always #2.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [5:0] arb(input logic [14:0] p, input logic [14:0] h);
    for (int j = 0; j < 15; j++)
      if (p[j] && h[j])
        return {1'b1, 5'(j)};
    for (int j = 0; j < 15; j++)
      if (p[j])
        return {1'b0, 5'(j)};
    return {1'b0, iep_pkg::NO_VECTOR};
  endfunction
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    total_checks++;
    if (s !== x)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {a, 2'b00};
    wb_dat_i <= {24'h00_0000, d};
    do
    begin
      @(posedge ref_clk);
      t++;
    end
    while (!(wb_ack_o || wb_err_o) && t < 20);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (!(wb_ack_o || wb_err_o))
    begin
      n_errors++;
      give_verdict();
    end
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (ra[j])
    begin
      bus(1'b0, ra[j], 8'h00);
      chk("reset value", 32'h0000_0000, q);
    end
    for (k = 0; k < 24; k++)
    begin
      rnd = lfsr(rnd);
      bus(1'b1, ra[k % 6], rnd[7:0]);
      bus(1'b0, ra[k % 6], 8'h00);
      chk("read back", {24'h00_0000, rnd[7:0] & rm[k % 6]}, q);
      bus(1'b1, ra[k % 6], 8'h00);
    end
    bus(1'b1, 10'h3ff, 8'hff);
    chk("unmapped", 32'h0000_0001, {31'h0, e});
    wb_sel_i <= 4'h0;
    bus(1'b1, iep_pkg::IRQ_PRIO1_IDX, 8'h5a);
    wb_sel_i <= 4'h1;
    bus(1'b0, iep_pkg::IRQ_PRIO1_IDX, 8'h00);
    chk("lane off", 32'h0000_0000, q);
    $display("registers done");
    bus(1'b1, iep_pkg::GLOBAL_CTRL_IDX, 8'h80);
    bus(1'b1, iep_pkg::IRQ_ENABLE1_IDX, 8'hff);
    bus(1'b1, iep_pkg::SERIAL_EN2_IDX, 8'h1f);
    for (k = 0; k < 10; k++)
    begin
      rnd = lfsr(rnd);
      p1 = k == 0 ? 8'h80 : (k == 1 ? 8'h00 : rnd[31:24]);
      group1_irq <= k < 2 ? 8'h81 : rnd[7:0];
      serial_irq <= k < 2 ? 5'h00 : rnd[20:16];
      bus(1'b1, iep_pkg::IRQ_PRIO1_IDX, p1);
      bus(1'b1, iep_pkg::SERIAL_PRIO2_IDX, {3'h0, rnd[12:8]});
      exp_v = arb({2'b00, serial_irq, group1_irq}, {2'b00, rnd[12:8], p1});
      for (i = 0; i < 20 && {irq_high, irq_vector} !== exp_v; i++)
        @(posedge ref_clk);
      chk("vector", {26'h0, exp_v}, {26'h0, irq_high, irq_vector});
      chk("request", {31'h0, exp_v[4:0] != 5'h1f}, {31'h0, irq_req});
      bus(1'b0, iep_pkg::PENDING_IDX, 8'h00);
      chk("pending", {24'h00_0000, exp_v[4:0] != 5'h1f, exp_v[5], 1'b0, exp_v[4:0]}, q);
    end
    group1_irq <= 8'h01;
    bus(1'b1, iep_pkg::GLOBAL_CTRL_IDX, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk("gated", 32'h0000_0000, {31'h0, irq_req});
    group1_irq <= 8'h00;
    serial_irq <= 5'h00;
    $display("arbitration done");
    bus(1'b1, iep_pkg::EXT0_FALL_IDX, 8'hf0);
    external_irq_zero[4] <= 1'b0;
    external_irq_one <= 1'b0;
    repeat (8) @(posedge ref_clk);
    bus(1'b0, iep_pkg::TIMER_CONTROL_IDX, 8'h00);
    chk("flags set", 32'h0000_000a, q);
    run <= 1'b1;
    slow <= rnd[0];
    bus(1'b1, iep_pkg::GLOBAL_CTRL_IDX, 8'h85);
    repeat (40) @(posedge ref_clk);
    bus(1'b0, iep_pkg::TIMER_CONTROL_IDX, 8'h00);
    chk("flags cleared", 32'h0000_0000, q);
    run <= 1'b0;
    bus(1'b1, iep_pkg::EXT0_FALL_IDX, 8'h00);
    bus(1'b1, iep_pkg::EXT0_RISE_IDX, 8'h10);
    external_irq_zero[4] <= 1'b1;
    repeat (8) @(posedge ref_clk);
    bus(1'b0, iep_pkg::TIMER_CONTROL_IDX, 8'h00);
    chk("rise flag", 32'h0000_0002, q);
    $display("external done");
    give_verdict();
  end
endmodule // tb_top
bind iep_ctrl iep_ctrl_monitor mon
(
  .ref_clk  (ref_clk),
  .reset    (reset),
  .wb_cyc_i (wb_cyc_i),
  .wb_stb_i (wb_stb_i),
  .wb_we_i  (wb_we_i),
  .wb_adr_i (wb_adr_i),
  .wb_dat_o (wb_dat_o),
  .wb_ack_o (wb_ack_o),
  .wb_err_o (wb_err_o)
);
